//--- tb_top.sv
// self-checking bench of the trinary code link against a far-end model
// assumes trc_far_end.sv and the design files are compiled first
`timescale 1ns/1ps

`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
	localparam int EC = 20;
	// ==========================================================
	// stimulus and results
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic send_n = 1'b1;
	logic loop = 1'b0;
	logic stall = 1'b0;
	logic ready = 1'b0;
	logic enc_prev = 1'b0;
	logic [17:0] codes = 18'h0;
	logic [17:0] local_addr = 18'h0;
	logic [17:0] c, c2;
	logic [3:0] ep;
	wire [8:0] pin_in, pin_out, pin_oe_n;
	wire far_line, enc_out, osc_run, flag, we_ev, te_ev, pv;
	wire [3:0] pay_out, pw;
	wire flag2;
	wire [3:0] pay2;
	logic [3:0] exp_pay[$];
	bit exp_enc[$];
	bit e;
	int seed = 32'h65D636AA;
	int num_errors = 0, n_tests = 0, cycles = 0, t0 = 0;
	int enc_cnt = 0, hi_cnt = 0, lo_cnt = 0, hi_last = 0, we_cnt = 0, te_cnt = 0;
	int gap_exp = 0;
	wire dec_in = loop ? enc_out : far_line;

	// ==========================================================
	// clock, design and far end
	always #5 sys_clk = ~sys_clk;
	trc_link #(.ENC_CYC(EC), .ADDR_ONLY(1'b0), .CW(24)) u_dut (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .SEND_REQUEST_N(send_n),
		.ADDRESS_PINS_IN(pin_in[4:0]), .ADDRESS_PINS_OUT(pin_out[4:0]),
		.ADDRESS_PINS_OE_N(pin_oe_n[4:0]), .ADDR_OR_PAYLOAD_PINS_IN(pin_in[8:5]),
		.ADDR_OR_PAYLOAD_PINS_OUT(pin_out[8:5]), .ADDR_OR_PAYLOAD_PINS_OE_N(pin_oe_n[8:5]),
		.ENC_DATA_OUT(enc_out), .OSC_RUN(osc_run), .DEC_DATA_IN(dec_in),
		.LOCAL_ADDR_CODE(local_addr), .VALID_FRAME_FLAG(flag), .PAYLOAD_OUTPUTS(pay_out),
		.WORD_END_EVENT(we_ev), .TRANSMISSION_END_EVENT(te_ev), .PAYLOAD_VALID(pv),
		.PAYLOAD_READY(ready), .PAYLOAD_WORD(pw));
	trc_far_end #(.EC(EC)) u_far (.clk(sys_clk), .codes(codes), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pin_in(pin_in), .line(far_line));
	// address-only decoder on the far-end line
	trc_link #(.ENC_CYC(EC), .ADDR_ONLY(1'b1), .CW(24)) u_dut2 (
		.SYS_CLK(sys_clk), .RST_N(rst_n), .SEND_REQUEST_N(1'b1),
		.ADDRESS_PINS_IN(5'h00), .ADDRESS_PINS_OUT(), .ADDRESS_PINS_OE_N(),
		.ADDR_OR_PAYLOAD_PINS_IN(4'h0), .ADDR_OR_PAYLOAD_PINS_OUT(),
		.ADDR_OR_PAYLOAD_PINS_OE_N(), .ENC_DATA_OUT(), .OSC_RUN(), .DEC_DATA_IN(far_line),
		.LOCAL_ADDR_CODE(local_addr), .VALID_FRAME_FLAG(flag2), .PAYLOAD_OUTPUTS(pay2),
		.WORD_END_EVENT(), .TRANSMISSION_END_EVENT(), .PAYLOAD_VALID(),
		.PAYLOAD_READY(1'b1), .PAYLOAD_WORD());

	// reader of the payload stream stalls at random or on demand
	always @(negedge sys_clk) ready <= stall ? 1'b0 : 1'($random(seed));

	// ==========================================================
	// helpers
	function automatic logic [17:0] rnd_codes();
		logic [17:0] r;
		for (int i = 0; i < 9; i++) r[2*i +: 2] = 2'($unsigned($random(seed)) % 3);
		return r;
	endfunction : rnd_codes

	function automatic logic [3:0] pay_of(input logic [17:0] d);
		logic [3:0] p;
		for (int i = 0; i < 4; i++) p[i] = d[2*(i+5) +: 2] != 2'h0;
		return p;
	endfunction : pay_of

	task automatic wait_cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wait_cyc

	// notes the pulse kinds of one two-word sequence
	task automatic note_enc(input logic [17:0] d);
		for (int w = 0; w < 18; w++) begin
			exp_enc.push_back(d[2*(w%9) +: 2] != 2'h0);
			exp_enc.push_back(d[2*(w%9) +: 2] == 2'h1);
		end
	endtask : note_enc

	// a far-end sequence, then enough silence for a word end
	task automatic far_seq(input logic [17:0] a, input logic [17:0] b, input bit spoil);
		u_far.seq(a, b, spoil);
		wait_cyc(300);
	endtask : far_seq

	task automatic summarize();
		if (num_errors == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// ==========================================================
	// watcher: line pulses, payload stream, events, hang limit
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 100000) begin
			num_errors++;
			summarize();
		end
		if (enc_out === 1'b1 && enc_prev === 1'b0) begin
			// a repeat adds the sensing of nine pins, two phases of four cycles each
			gap_exp = 8 * EC - hi_last + 24 * EC + ((enc_cnt % 36 == 0) ? 72 : 0);
			if (enc_cnt % 18 == 0 && enc_cnt != 0) `CHK("word gap", lo_cnt, gap_exp)
			hi_cnt = 0;
		end
		if (enc_out === 1'b0 && enc_prev === 1'b1) begin
			hi_last = hi_cnt;
			lo_cnt = 0;
			enc_cnt++;
			`CHK("pulse expected", exp_enc.size() > 0, 1'b1)
			if (exp_enc.size() > 0) e = exp_enc.pop_front();
			`CHK("pulse width", hi_cnt, e ? 4 * EC : EC)
		end
		if (pv === 1'b1 && ready === 1'b1) begin
			`CHK("payload expected", exp_pay.size() > 0, 1'b1)
			if (exp_pay.size() > 0) ep = exp_pay.pop_front();
			`CHK("payload word", pw, ep)
		end
		we_cnt += (we_ev === 1'b1);
		te_cnt += (te_ev === 1'b1);
		if (enc_out === 1'b1) hi_cnt++;
		else lo_cnt++;
		enc_prev = enc_out;
	end

	// ==========================================================
	// main sequence
	initial begin
		wait_cyc(12);
		rst_n = 1'b1;
		wait_cyc(700);
		// brief request; the first run after power-up is not decoded
		c = rnd_codes();
		codes = c;
		note_enc(c);
		send_n = 1'b0;
		wait_cyc(2);
		send_n = 1'b1;
		wait_cyc(5);
		`CHK("osc run", osc_run, 1'b1)
		wait_cyc(7500);
		`CHK("pulses left", exp_enc.size(), 0)
		`CHK("osc idle", osc_run, 1'b0)
		// held request repeats sequences into the local decoder
		c = rnd_codes();
		codes = c;
		local_addr = c;
		loop = 1'b1;
		enc_cnt = 0;
		note_enc(c);
		note_enc(c);
		exp_pay.push_back(pay_of(c));
		exp_pay.push_back(pay_of(c));
		send_n = 1'b0;
		for (int k = 0; k < 9000 && enc_cnt < 40; k++) @(negedge sys_clk);
		send_n = 1'b1;
		wait_cyc(7000);
		`CHK("pulses left", exp_enc.size(), 0)
		`CHK("payloads left", exp_pay.size(), 0)
		`CHK("flag after silence", flag, 1'b0)
		`CHK("latched payload", pay_out, pay_of(c))
		loop = 1'b0;
		// pulses either side of the width threshold, then a spoilt word
		c = rnd_codes();
		local_addr = c;
		u_far.short_w = 34;
		u_far.long_w = 35;
		exp_pay.push_back(pay_of(c));
		t0 = we_cnt;
		far_seq(c, c, 1'b0);
		`CHK("flag", flag, 1'b1)
		`CHK("payload", pay_out, pay_of(c))
		`CHK("word ends", we_cnt - t0, 2)
		`CHK("ao flag", flag2, 1'b1)
		`CHK("ao payload", pay2, 4'h0)
		u_far.word(c, 1'b1);
		wait_cyc(300);
		`CHK("flag on bad word", flag, 1'b0)
		`CHK("ao flag on bad word", flag2, 1'b0)
		`CHK("payload held", pay_out, pay_of(c))
		t0 = te_cnt;
		wait_cyc(500);
		`CHK("end events", te_cnt - t0, 1)
		// address miss, payload change between words, pulses under threshold
		for (int k = 0; k < 3; k++) begin
			c = rnd_codes();
			c[1:0] = 2'h1;
			c2 = c;
			local_addr = c;
			u_far.short_w = EC;
			u_far.long_w = (k == 2) ? 34 : 4 * EC;
			if (k == 0) local_addr[1:0] = 2'h0;
			if (k == 1) c2[17:16] = (c[17:16] == 2'h0) ? 2'h1 : 2'h0;
			far_seq(c, c2, 1'b0);
			`CHK("flag on miss", flag, 1'b0)
			`CHK("ao flag on miss", flag2, 1'b0)
			wait_cyc(500);
		end
		// three loads while the reader stalls, then drained in order
		stall = 1'b1;
		u_far.long_w = 4 * EC;
		for (int k = 0; k < 3; k++) begin
			c = rnd_codes();
			c[13:10] = (k == 0) ? 4'h0 : ((k == 1) ? 4'h1 : 4'h4);
			local_addr = c;
			exp_pay.push_back(pay_of(c));
			far_seq(c, c, 1'b0);
			wait_cyc(500);
		end
		`CHK("stalled valid", pv, 1'b1)
		stall = 1'b0;
		wait_cyc(60);
		`CHK("payloads left", exp_pay.size(), 0)
		`CHK("drained valid", pv, 1'b0)
		// reset in mid-run clears flag, latch and buffered word
		stall = 1'b1;
		c = rnd_codes();
		c[11:10] = 2'h1;
		local_addr = c;
		far_seq(c, c, 1'b0);
		rst_n = 1'b0;
		wait_cyc(3);
		`CHK("reset flag", flag, 1'b0)
		`CHK("reset payload", pay_out, 4'h0)
		`CHK("reset valid", pv, 1'b0)
		rst_n = 1'b1;
		wait_cyc(5);
		summarize();
	end
endmodule : tb_top

//--- trc_far_end.sv
// far end of the trinary code link: remote encoder line and trinary pins
// assumes the bench calls its tasks just after a falling clock edge
`timescale 1ns/1ps

module trc_far_end #(
	parameter int EC = 20
) (
	// clock
	input wire logic clk,
	// trinary pins seen by the local encoder
	input wire logic [17:0] codes,
	input wire logic [8:0] pin_out,
	input wire logic [8:0] pin_oe_n,
	output logic [8:0] pin_in,
	// serial line towards the local decoder
	output logic line
);
	int short_w = EC;
	int long_w = 4 * EC;
	logic tgl = 1'b0;

	// ==========================================================
	// pins
	// a released open pin wanders so a stale level is never read
	always @(negedge clk) tgl <= ~tgl;

	// tied pins win, an open pin follows the weak drive
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			case (codes[2*i +: 2])
				2'h0: pin_in[i] = 1'b0;
				2'h1: pin_in[i] = 1'b1;
				default: pin_in[i] = pin_oe_n[i] ? tgl : pin_out[i];
			endcase
		end
	end

	// ==========================================================
	// serial line
	// line rests low after power-up; nothing here leans on its first word
	initial line = 1'b0;

	// one pulse inside a data period of eight encoder clocks
	task automatic pulse(input bit wide);
		int hi;
		hi = wide ? long_w : short_w;
		line = 1'b1;
		repeat (hi) @(negedge clk);
		line = 1'b0;
		repeat (8 * EC - hi) @(negedge clk);
	endtask : pulse

	// nine digits; a spoilt word ends in a short-long pair
	task automatic word(input logic [17:0] c, input bit spoil);
		for (int i = 0; i < 9; i++) begin
			if (spoil && i == 8) begin
				pulse(1'b0);
				pulse(1'b1);
			end else begin
				pulse(c[2*i +: 2] != 2'h0);
				pulse(c[2*i +: 2] == 2'h1);
			end
		end
	endtask : word

	// two words with an idle gap of three data periods
	task automatic seq(input logic [17:0] a, input logic [17:0] b, input bit spoil);
		word(a, 1'b0);
		repeat (24 * EC) @(negedge clk);
		word(b, spoil);
	endtask : seq
endmodule : trc_far_end

//--- trc_fifo2.sv
// small word buffer with valid/ready on both sides
// assumes one clock; the drain side may stall at will
`timescale 1ns/1ps

module trc_fifo2 #(
	parameter int W = 4,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r, rp_r;
	logic [AW:0] cnt_r;
	logic push, pop;

	// handshakes and honest full/empty
	assign in_ready = cnt_r != (AW+1)'(DEPTH);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : trc_fifo2

//--- trc_link.sv
// trinary remote code link: encoder and decoder of one device
// assumes a 100 MHz clock; pins other than RST_N and PAYLOAD_READY asynchronous, synchronised here
`timescale 1ns/1ps
`include "trc_params.svh"

module trc_link
	import trc_pkg::*;
#(
	parameter int ENC_CYC = `TRC_ENC_PERIOD_NS / `TRC_SYS_PERIOD_NS,
	parameter bit ADDR_ONLY = 1'b0,
	parameter int CW = 24
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RST_N,
	// encoder request and sensed pins
	input wire logic SEND_REQUEST_N,
	input wire logic [4:0] ADDRESS_PINS_IN,
	output logic [4:0] ADDRESS_PINS_OUT,
	output logic [4:0] ADDRESS_PINS_OE_N,
	input wire logic [3:0] ADDR_OR_PAYLOAD_PINS_IN,
	output logic [3:0] ADDR_OR_PAYLOAD_PINS_OUT,
	output logic [3:0] ADDR_OR_PAYLOAD_PINS_OE_N,
	// encoder serial line and oscillator state
	output logic ENC_DATA_OUT,
	output logic OSC_RUN,
	// decoder line and local address
	input wire logic DEC_DATA_IN,
	input wire logic [17:0] LOCAL_ADDR_CODE,
	// decoder results
	output logic VALID_FRAME_FLAG,
	output logic [3:0] PAYLOAD_OUTPUTS,
	output logic WORD_END_EVENT,
	output logic TRANSMISSION_END_EVENT,
	// buffered payload stream
	output logic PAYLOAD_VALID,
	input wire logic PAYLOAD_READY,
	output logic [3:0] PAYLOAD_WORD
);
	// ==========================================================
	// derived timing
	localparam logic [CW-1:0] SUB_LAST = CW'(ENC_CYC - 1);
	localparam logic [CW-1:0] THR_C = CW'((ENC_CYC * `TRC_PW_THR_X100 + 99) / 100);
	localparam int EOT_CYC = (ENC_CYC * `TRC_EOT_X10) / 10;
	localparam logic [CW-1:0] EOT_C = CW'(EOT_CYC - 1);
	localparam logic [CW-1:0] EOW_C = CW'((EOT_CYC * `TRC_EOW_OF_EOT_X10) / 10 - 1);
	localparam int NCMP = ADDR_ONLY ? 9 : `TRC_ADDR_DIGITS;

	// digit i of a packed code
	function automatic trc_digit_t dig_of(input logic [17:0] c, input logic [3:0] i);
		return c[2*i +: 2];
	endfunction : dig_of

	// whether half h of a digit is a long pulse
	function automatic logic long_pulse(input trc_digit_t dg, input logic h);
		return (dg == `TRC_DG_HIGH) || (dg == `TRC_DG_OPEN && !h);
	endfunction : long_pulse

	// digit from two received pulse widths
	function automatic trc_digit_t pair_dig(input logic w0, input logic w1);
		case ({w0, w1})
			2'b00: return `TRC_DG_LOW;
			2'b11: return `TRC_DG_HIGH;
			2'b10: return `TRC_DG_OPEN;
			default: return `TRC_DG_BAD;
		endcase
	endfunction : pair_dig

	// ==========================================================
	// pin synchronisers
	logic send_n_s, rx_s;
	logic [8:0] pin_in_s;
	logic [17:0] loc_s;

	trc_sync #(.W(29), .INIT({1'b1, 28'h0000000})) u_sync (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.d({SEND_REQUEST_N, ADDR_OR_PAYLOAD_PINS_IN, ADDRESS_PINS_IN, DEC_DATA_IN,
			LOCAL_ADDR_CODE}),
		.q({send_n_s, pin_in_s, rx_s, loc_s})
	);

	// ==========================================================
	// encoder
	trc_enc_e enc_st_r;
	logic [CW-1:0] sub_r;
	logic [5:0] eclk_r;
	logic [3:0] dig_r;
	logic [2:0] scnt_r;
	logic [17:0] code_r;
	logic half_r, word_r, hi_seen_r, dout_r;
	logic tick, lo_res;
	logic [5:0] hi_len;
	logic [8:0] pin_out, pin_oe_n;

	assign tick = sub_r == SUB_LAST;
	assign lo_res = !pin_in_s[dig_r];
	assign OSC_RUN = enc_st_r != TRC_ENC_IDLE;
	assign ENC_DATA_OUT = dout_r;

	// oscillator: stopped while idle, held in sensing so the first period is whole
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || enc_st_r == TRC_ENC_IDLE || enc_st_r == TRC_ENC_SENSE) begin
			sub_r <= '0;
		end else if (tick) begin
			sub_r <= '0;
		end else begin
			sub_r <= sub_r + 1'b1;
		end
	end

	// sequencer: sense, word one, gap, word two, gap
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			enc_st_r <= TRC_ENC_IDLE;
			eclk_r <= '0;
			dig_r <= '0;
			scnt_r <= '0;
			half_r <= 1'b0;
			word_r <= 1'b0;
			hi_seen_r <= 1'b0;
			code_r <= '0;
		end else begin
			case (enc_st_r)
				TRC_ENC_IDLE: begin
					if (!send_n_s) begin
						enc_st_r <= TRC_ENC_SENSE;
						dig_r <= '0;
						half_r <= 1'b0;
						scnt_r <= '0;
					end
				end
				TRC_ENC_SENSE: begin
					scnt_r <= scnt_r + 1'b1;
					if (scnt_r == `TRC_SENSE_CYC - 3'h1) begin
						scnt_r <= '0;
						half_r <= !half_r;
						if (!half_r) begin
							hi_seen_r <= pin_in_s[dig_r];
						end else begin
							// both forced levels seen means open
							if (hi_seen_r && lo_res) begin
								code_r[2*dig_r +: 2] <= `TRC_DG_OPEN;
							end else if (hi_seen_r) begin
								code_r[2*dig_r +: 2] <= `TRC_DG_HIGH;
							end else if (lo_res) begin
								code_r[2*dig_r +: 2] <= `TRC_DG_LOW;
							end else begin
								code_r[2*dig_r +: 2] <= `TRC_DG_OPEN;
							end
							if (dig_r == `TRC_LAST_DIGIT) begin
								enc_st_r <= TRC_ENC_SEND;
								dig_r <= '0;
								eclk_r <= '0;
								word_r <= 1'b0;
							end else begin
								dig_r <= dig_r + 1'b1;
							end
						end
					end
				end
				TRC_ENC_SEND: begin
					if (tick) begin
						if (eclk_r == `TRC_DATA_PER - 6'h01) begin
							eclk_r <= '0;
							half_r <= !half_r;
							if (half_r) begin
								if (dig_r == `TRC_LAST_DIGIT) begin
									enc_st_r <= TRC_ENC_GAP;
									dig_r <= '0;
									word_r <= !word_r;
								end else begin
									dig_r <= dig_r + 1'b1;
								end
							end
						end else begin
							eclk_r <= eclk_r + 1'b1;
						end
					end
				end
				TRC_ENC_GAP: begin
					if (tick) begin
						if (eclk_r == `TRC_GAP_LEN - 6'h01) begin
							eclk_r <= '0;
							half_r <= 1'b0;
							scnt_r <= '0;
							if (word_r) begin
								enc_st_r <= TRC_ENC_SEND;
							end else if (!send_n_s) begin
								enc_st_r <= TRC_ENC_SENSE;
							end else begin
								enc_st_r <= TRC_ENC_IDLE;
							end
						end else begin
							eclk_r <= eclk_r + 1'b1;
						end
					end
				end
				default: begin
					enc_st_r <= TRC_ENC_IDLE;
				end
			endcase
		end
	end

	// pulse shaping: high for the short or long part of each data period
	assign hi_len = long_pulse(dig_of(code_r, dig_r), half_r) ? `TRC_LONG_HI : `TRC_SHORT_HI;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			dout_r <= 1'b0;
		end else begin
			dout_r <= (enc_st_r == TRC_ENC_SEND) && (eclk_r < hi_len);
		end
	end

	// weak drive of the selected pin, high then low
	for (genvar i = 0; i < 9; i++) begin : g_drive
		assign pin_oe_n[i] = !(enc_st_r == TRC_ENC_SENSE && dig_r == 4'(i));
		assign pin_out[i] = !half_r;
	end
	assign ADDRESS_PINS_OUT = pin_out[4:0];
	assign ADDRESS_PINS_OE_N = pin_oe_n[4:0];
	assign ADDR_OR_PAYLOAD_PINS_OUT = pin_out[8:5];
	assign ADDR_OR_PAYLOAD_PINS_OE_N = pin_oe_n[8:5];

	// ==========================================================
	// decoder: pulse width and low time timers
	logic rx_d_r, p0_r, bad_r, fall, wide, word_end_event, transmission_end_event, word_evt;
	logic [CW-1:0] hi_cnt_r, lo_cnt_r;
	logic [4:0] pcnt_r;
	logic [17:0] rx_code_r;

	assign fall = rx_d_r && !rx_s;
	assign wide = hi_cnt_r >= THR_C;
	assign word_end_event = !rx_s && lo_cnt_r == EOW_C;
	assign transmission_end_event = !rx_s && lo_cnt_r == EOT_C;
	assign word_evt = word_end_event && pcnt_r != '0;

	// pulse width timer and gap timer
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			rx_d_r <= 1'b0;
			hi_cnt_r <= '0;
			lo_cnt_r <= '0;
		end else begin
			rx_d_r <= rx_s;
			hi_cnt_r <= rx_s ? hi_cnt_r + CW'(hi_cnt_r != '1) : '0;
			lo_cnt_r <= rx_s ? '0 : lo_cnt_r + CW'(lo_cnt_r != '1);
		end
	end

	// pulse pairing into digits
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N || word_end_event) begin
			pcnt_r <= '0;
			bad_r <= 1'b0;
			p0_r <= 1'b0;
		end else if (fall) begin
			pcnt_r <= pcnt_r + 5'(pcnt_r != 5'h1F);
			if (!pcnt_r[0]) begin
				p0_r <= wide;
			end else if (pcnt_r < `TRC_PULSES) begin
				rx_code_r[2*pcnt_r[4:1] +: 2] <= pair_dig(p0_r, wide);
				if (pair_dig(p0_r, wide) == `TRC_DG_BAD) begin
					bad_r <= 1'b1;
				end
			end
			if (pcnt_r >= `TRC_PULSES) begin
				bad_r <= 1'b1;
			end
		end
	end

	// ==========================================================
	// decoder: word check and frame state
	logic [8:0] dmatch;
	logic [3:0] rx_pay, stored_r, latch_r, pend_w_r;
	logic word_good, load, first_ok_r, valid_r, pend_v_r, buf_ready, weow_r, weot_r;

	for (genvar i = 0; i < 9; i++) begin : g_match
		assign dmatch[i] = (i >= NCMP) || dig_of(rx_code_r, 4'(i)) == dig_of(loc_s, 4'(i));
	end
	for (genvar j = 0; j < 4; j++) begin : g_pay
		assign rx_pay[j] = dig_of(rx_code_r, 4'(5 + j)) != `TRC_DG_LOW;
	end

	assign word_good = pcnt_r == `TRC_PULSES && !bad_r && &dmatch;
	assign load = word_evt && word_good && first_ok_r && (ADDR_ONLY || rx_pay == stored_r);

	// flag and first-word store
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			valid_r <= 1'b0;
			first_ok_r <= 1'b0;
			stored_r <= `TRC_PAY_RST;
		end else if (transmission_end_event) begin
			valid_r <= 1'b0;
			first_ok_r <= 1'b0;
		end else if (word_evt) begin
			if (!word_good) begin
				valid_r <= 1'b0;
				first_ok_r <= 1'b0;
			end else if (!first_ok_r) begin
				first_ok_r <= 1'b1;
				stored_r <= rx_pay;
			end else begin
				valid_r <= load;
				first_ok_r <= 1'b0;
			end
		end
	end

	// payload latch holds until the next valid frame
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			latch_r <= `TRC_PAY_RST;
		end else if (load) begin
			latch_r <= ADDR_ONLY ? `TRC_PAY_RST : rx_pay;
		end
	end

	// event outputs and pending push into the buffer
	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			weow_r <= 1'b0;
			weot_r <= 1'b0;
			pend_v_r <= 1'b0;
			pend_w_r <= `TRC_PAY_RST;
		end else begin
			weow_r <= word_evt;
			weot_r <= transmission_end_event;
			if (load) begin
				pend_v_r <= 1'b1;
				pend_w_r <= ADDR_ONLY ? `TRC_PAY_RST : rx_pay;
			end else if (buf_ready) begin
				pend_v_r <= 1'b0;
			end
		end
	end

	trc_fifo2 #(.W(4), .DEPTH(`TRC_BUF_DEPTH)) u_buf (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.in_valid(pend_v_r),
		.in_ready(buf_ready),
		.in_data(pend_w_r),
		.out_valid(PAYLOAD_VALID),
		.out_ready(PAYLOAD_READY),
		.out_data(PAYLOAD_WORD)
	);

	assign VALID_FRAME_FLAG = valid_r;
	assign PAYLOAD_OUTPUTS = latch_r;
	assign WORD_END_EVENT = weow_r;
	assign TRANSMISSION_END_EVENT = weot_r;

	// ==========================================================
	// assertions
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_N);

	property p_idle_quiet;
		enc_st_r == TRC_ENC_IDLE && $past(enc_st_r) == TRC_ENC_IDLE |-> !dout_r && !OSC_RUN;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("idle encoder not quiet");

	property p_start;
		enc_st_r == TRC_ENC_IDLE && !send_n_s |=> enc_st_r == TRC_ENC_SENSE;
	endproperty
	a_start: assert property (p_start) else $error("request did not start");

	property p_gap_quiet;
		enc_st_r == TRC_ENC_GAP && $past(enc_st_r) == TRC_ENC_GAP |-> !dout_r;
	endproperty
	a_gap_quiet: assert property (p_gap_quiet) else $error("pulse during gap");

	property p_one_pin;
		enc_st_r == TRC_ENC_SENSE |-> $countones(~pin_oe_n) == 1;
	endproperty
	a_one_pin: assert property (p_one_pin) else $error("not one pin driven");

	property p_eot_clear;
		transmission_end_event |=> !valid_r && !first_ok_r;
	endproperty
	a_eot_clear: assert property (p_eot_clear) else $error("flag kept after silence");

	property p_flag_cause;
		$rose(valid_r) |-> $past(load);
	endproperty
	a_flag_cause: assert property (p_flag_cause) else $error("flag rose without frame");

	property p_latch_hold;
		!load |=> $stable(latch_r);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch changed alone");

	property p_load_match;
		load |-> pcnt_r == `TRC_PULSES && &dmatch && first_ok_r;
	endproperty
	a_load_match: assert property (p_load_match) else $error("load without match");

	property p_open_one;
		load && !ADDR_ONLY && dig_of(rx_code_r, 4'h5) == `TRC_DG_OPEN |=> latch_r[0];
	endproperty
	a_open_one: assert property (p_open_one) else $error("open payload not one");

	c_frame: cover property (load);
	c_repeat: cover property (enc_st_r == TRC_ENC_GAP && !word_r ##1 enc_st_r == TRC_ENC_SENSE);
	c_stall: cover property (pend_v_r && !buf_ready);
endmodule : trc_link

//--- trc_params.svh
// constants of the trinary remote code link: timing, codes, sizes
// assumes a 100 MHz system clock; included by the package and by trc_link
//
// Functional notes
// - encoder sends nine trinary digits from five address and four shared pins
// - encoder starts a sequence when send_request_n goes low
// - repeats while request stays low; brief low pulse gives one two-word sequence
// - line stays idle for three data periods between the two words
// - low = short,short; high = long,long; open = long,short
// - pin driven weakly high then low; both results mean open
// - idle with oscillator stopped when request high and sequence done
// - on request start oscillator, sense pins in turn, shift pulses out
// - first word: five address digits match, then store four payload bits
// - second word: address and payload match, then load latch and raise flag
// - payload latch holds until a later valid frame
// - flag drops on a mismatching word or four silent data periods
// - open payload digit decodes as logic one
// - address-only variant compares nine digits, flag after two matching words
// - pulse is wide when high longer than 1.72 encoder clocks
// - end of transmission after line low for 33.5 encoder clocks
// - word end event after line low for 13.4 encoder clocks
`ifndef TRC_PARAMS_SVH
`define TRC_PARAMS_SVH

// ==========================================================
// timing
`define TRC_SYS_PERIOD_NS 10
`define TRC_ENC_PERIOD_NS 100000
`define TRC_PW_THR_X100 172
`define TRC_EOT_X10 335
`define TRC_EOW_OF_EOT_X10 4
`define TRC_DATA_PER 6'h08
`define TRC_SHORT_HI 6'h01
`define TRC_LONG_HI 6'h04
`define TRC_GAP_LEN 6'h18
`define TRC_SENSE_CYC 3'h4

// ==========================================================
// word layout and digit codes
`define TRC_LAST_DIGIT 4'h8
`define TRC_ADDR_DIGITS 5
`define TRC_PULSES 5'h12
`define TRC_DG_LOW 2'h0
`define TRC_DG_HIGH 2'h1
`define TRC_DG_OPEN 2'h2
`define TRC_DG_BAD 2'h3
`define TRC_PAY_RST 4'h0
`define TRC_BUF_DEPTH 2

`endif

//--- trc_pkg.sv
// types of the trinary remote code link
// assumes trc_params.svh is on the include path
`include "trc_params.svh"

package trc_pkg;
	// encoder sequencer states
	typedef enum logic [1:0] {TRC_ENC_IDLE, TRC_ENC_SENSE, TRC_ENC_SEND, TRC_ENC_GAP} trc_enc_e;
	// one trinary digit
	typedef logic [1:0] trc_digit_t;
endpackage : trc_pkg

//--- trc_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes inputs may change at any time relative to clk
`timescale 1ns/1ps

module trc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= INIT;
			q <= INIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : trc_sync
